// file: ifp_core.sv
// Behaviour
// RULE1: Plain instructions take one instruction cycle; PC-changing ones take two.
// RULE2: Taken branch flushes the fetched word to a NOP while fetching the target.
// RULE3: Program memory is byte addressed; instructions are two or four bytes.
// RULE4: Instruction low byte sits at even address, high byte at next odd one.
// RULE5: Program counter steps by two bytes per word; its lowest bit is zero.
// RULE6: Absolute jump and call load the word address into counter bits 20..1.
// RULE7: Relative branch offset counts words, so the byte displacement is double.
// RULE8: Four two-word instructions; second word has 1111 on top, 12-bit literal.
// RULE9: Second word run straight after its first supplies the literal to it.
// RULE10: A 1111-prefixed word run on its own executes as a no-operation.
// RULE11: Data locations carry 12-bit addresses, up to 4096 bytes.
// RULE12: Data memory is 16 banks of 256 bytes, all implemented.
// RULE13: Reads from unimplemented data locations return zero.
// RULE14: Every data location is reachable across all banks.
// RULE15: A 256-byte fast window reaches registers and low bank zero, ignoring bank.
// RULE16: Clock splits into four phases; counter steps in phase one, fetch latches in four.
// RULE17: Operand is read in phase two and destination written in phase four.
// RULE18: Fast window is bank zero 00-7f followed by bank fifteen 80-ff.
// RULE19: Access bit 1 uses bank select value; bit 0 uses the fast window.
// RULE20: A finished non-branching two-word instruction continues four bytes on.
`timescale 1ns/1ns

module ifp_core #(
  parameter int NUM_BANKS = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic [ifp_pkg::PC_W-1:0] pm_addr,
  input wire logic [ifp_pkg::IW_W-1:0] pm_rdata,
  input wire logic [ifp_pkg::BANK_W-1:0] bank_select_value,
  output logic [ifp_pkg::DA_W-1:0] dm_addr,
  output logic dm_rd,
  output logic dm_wr,
  output logic [ifp_pkg::DD_W-1:0] dm_wdata,
  input wire logic [ifp_pkg::DD_W-1:0] dm_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  ifp_pkg::ifp_phase_t phase, next_phase;
  logic [ifp_pkg::PCW_W-1:0] pc, next_pc;
  logic [ifp_pkg::IW_W-1:0] ir, next_ir;
  logic ir_valid, next_ir_valid;
  logic ir_second, next_ir_second;
  logic fetch_live, next_fetch_live;
  logic rd_req, next_rd_req;
  logic rd_hit, next_rd_hit;
  logic [ifp_pkg::DD_W-1:0] operand, next_operand;
  logic prev_move, next_prev_move;
  logic [ifp_pkg::PC_W-1:0] next_pm_addr;
  logic [ifp_pkg::DA_W-1:0] next_dm_addr;
  logic next_dm_rd;
  logic next_dm_wr;
  logic [ifp_pkg::DD_W-1:0] next_dm_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the word in the execute stage.

  logic first_ok;
  logic is_move, is_jump, is_call, is_ptr, is_bra, is_test;
  logic two_word, plain_read;
  logic [ifp_pkg::OFF_W-1:0] f_off;
  logic [ifp_pkg::DA_W-1:0] file_addr, rd_addr;
  logic [ifp_pkg::PCW_W-1:0] abs_target, rel_target;
  logic [ifp_pkg::PCW_W-1:0] rel_words;

  // A 1111-prefixed word is only meaningful as a tracked second word.
  always_comb begin
    first_ok = ir_valid && !ir_second
      && (ir[15:12] != ifp_pkg::OP_SECOND_WORD); // RULE10
    is_move = first_ok && (ir[15:12] == ifp_pkg::OP_MOVE_FULL);
    is_jump = first_ok && (ir[15:8] == ifp_pkg::OP_JUMP_ABS);
    is_call = first_ok && (ir[15:9] == ifp_pkg::OP_CALL_ABS);
    is_ptr = first_ok && (ir[15:6] == ifp_pkg::OP_PTR_LOAD);
    is_bra = first_ok && (ir[15:11] == ifp_pkg::OP_BRANCH_REL);
    is_test = first_ok && (ir[15:9] == ifp_pkg::OP_TEST_SKIP);
    two_word = is_move || is_jump || is_call || is_ptr; // RULE8
    plain_read = first_ok && !two_word && !is_bra;
    f_off = ir[ifp_pkg::OFF_W-1:0];
    // Access bit chooses banked or fast-window addressing.
    if (ir[ifp_pkg::ACCESS_SEL_BIT]) begin
      file_addr = {bank_select_value, f_off}; // RULE19 RULE14
    end else if (f_off < ifp_pkg::ACC_SPLIT) begin
      file_addr = {ifp_pkg::ACC_LO_BANK, f_off}; // RULE15 RULE18
    end else begin
      file_addr = {ifp_pkg::ACC_HI_BANK, f_off}; // RULE18
    end
    // The full move carries its whole 12-bit source address.
    rd_addr = is_move ? ir[ifp_pkg::LIT_W-1:0] : file_addr; // RULE11
    // The incoming second word holds the upper target bits.
    abs_target = {pm_rdata[ifp_pkg::LIT_W-1:0],
                  ir[ifp_pkg::ABS_LO_W-1:0]}; // RULE6 RULE9
    rel_words = {{(ifp_pkg::PCW_W-ifp_pkg::REL_OFF_W)
                  {ir[ifp_pkg::REL_OFF_W-1]}},
                 ir[ifp_pkg::REL_OFF_W-1:0]};
    // The counter already points two words past the branch.
    rel_target = pc - ifp_pkg::PC_BRANCH_BACK + rel_words; // RULE7
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing, fetch and execute.

  logic branch, skip;
  logic [ifp_pkg::PCW_W-1:0] fetch_word;

  // Every action is tied to one phase, so memories see one strobe per cycle.
  always_comb begin
    next_phase = phase;
    next_pc = pc;
    next_ir = ir;
    next_ir_valid = ir_valid;
    next_ir_second = ir_second;
    next_fetch_live = fetch_live;
    next_rd_req = rd_req;
    next_rd_hit = rd_hit;
    next_operand = operand;
    next_pm_addr = pm_addr;
    next_dm_addr = dm_addr;
    next_dm_rd = 1'b0;
    next_dm_wr = 1'b0;
    next_dm_wdata = dm_wdata;
    branch = 1'b0;
    skip = 1'b0;
    fetch_word = pc;
    case (phase)
      ifp_pkg::phase_one: begin
        next_phase = ifp_pkg::phase_two; // RULE16
        next_rd_req = is_move || is_test || plain_read;
        next_rd_hit = int'(rd_addr[ifp_pkg::DA_W-1 -: ifp_pkg::BANK_W])
          < NUM_BANKS; // RULE12
        next_dm_addr = rd_addr;
        next_dm_rd = next_rd_req && next_rd_hit; // RULE17
      end
      ifp_pkg::phase_two: begin
        next_phase = ifp_pkg::phase_three;
        // Read data arrives in the same cycle as the strobe.
        if (rd_req) begin
          next_operand = rd_hit ? dm_rdata : ifp_pkg::DATA_ZERO; // RULE13
        end
      end
      ifp_pkg::phase_three: begin
        next_phase = ifp_pkg::phase_four;
        // A tracked second word of the full move writes its destination.
        if (ir_valid && ir_second && ir[15:12] == ifp_pkg::OP_SECOND_WORD
            && prev_move) begin
          next_dm_addr = ir[ifp_pkg::LIT_W-1:0]; // RULE9
          next_dm_wdata = operand;
          next_dm_wr = int'(ir[ifp_pkg::LIT_W-1 -: ifp_pkg::BANK_W])
            < NUM_BANKS; // RULE17 RULE13
        end
      end
      ifp_pkg::phase_four: begin
        next_phase = ifp_pkg::phase_one;
        // Jumps resolve here, with the second word on the fetch bus.
        if (is_jump || is_call) begin
          branch = 1'b1;
          fetch_word = abs_target; // RULE6
        end else if (is_bra) begin
          branch = 1'b1;
          fetch_word = rel_target; // RULE7
        end
        skip = is_test && (operand == ifp_pkg::DATA_ZERO);
        // Latch the fetched word; a relative branch or skip kills it.
        next_fetch_live = 1'b1;
        next_ir = pm_rdata; // RULE16 RULE4
        // Jumps keep their second word, so only single-word branches flush.
        next_ir_valid = fetch_live
          && !((branch && !two_word) || skip); // RULE2 RULE1
        next_ir_second = two_word; // RULE9 RULE10
        // Counter steps by one word as the next fetch starts.
        next_pm_addr = {fetch_word, ifp_pkg::PC_LSB}; // RULE5 RULE3
        next_pc = fetch_word + ifp_pkg::PC_STEP_WORD; // RULE5 RULE20
      end
      default: begin
        next_phase = ifp_pkg::phase_four;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory of which first word owns the second word now executing.

  // Only the full move acts on its second word; jump and call already used it.
  always_comb begin
    next_prev_move = prev_move;
    if (phase == ifp_pkg::phase_four) begin
      next_prev_move = is_move;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Reset starts in phase four so the first fetch of word zero begins at once.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= ifp_pkg::phase_four;
      pc <= ifp_pkg::PC_RESET_WORD;
      ir <= '0;
      ir_valid <= 1'b0;
      ir_second <= 1'b0;
      fetch_live <= 1'b0;
      rd_req <= 1'b0;
      rd_hit <= 1'b0;
      operand <= ifp_pkg::DATA_ZERO;
      prev_move <= 1'b0;
      pm_addr <= '0;
      dm_addr <= '0;
      dm_rd <= 1'b0;
      dm_wr <= 1'b0;
      dm_wdata <= ifp_pkg::DATA_ZERO;
    end else begin
      phase <= next_phase;
      pc <= next_pc;
      ir <= next_ir;
      ir_valid <= next_ir_valid;
      ir_second <= next_ir_second;
      fetch_live <= next_fetch_live;
      rd_req <= next_rd_req;
      rd_hit <= next_rd_hit;
      operand <= next_operand;
      prev_move <= next_prev_move;
      pm_addr <= next_pm_addr;
      dm_addr <= next_dm_addr;
      dm_rd <= next_dm_rd;
      dm_wr <= next_dm_wr;
      dm_wdata <= next_dm_wdata;
    end
  end

endmodule : ifp_core

// file: ifp_pkg.sv
package ifp_pkg;

  // Widths of the program counter, instruction word and data address.
  localparam int PC_W = 21;
  localparam int PCW_W = 20;
  localparam int IW_W = 16;
  localparam int DA_W = 12;
  localparam int DD_W = 8;
  localparam int BANK_W = 4;
  localparam int OFF_W = 8;

  // Program counter values, counted in instruction words.
  localparam logic [PCW_W-1:0] PC_RESET_WORD = 20'h00000;
  localparam logic [PCW_W-1:0] PC_STEP_WORD = 20'h00001;
  localparam logic [PCW_W-1:0] PC_BRANCH_BACK = 20'h00001;
  localparam logic PC_LSB = 1'b0;

  // Opcode prefixes, matched on the top bits of the word.
  localparam logic [3:0] OP_MOVE_FULL = 4'hc;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;
  localparam logic [4:0] OP_BRANCH_REL = 5'h1a;
  localparam logic [7:0] OP_JUMP_ABS = 8'hef;
  localparam logic [6:0] OP_CALL_ABS = 7'h76;
  localparam logic [9:0] OP_PTR_LOAD = 10'h3b8;
  localparam logic [6:0] OP_TEST_SKIP = 7'h33;

  // Field positions inside an instruction word.
  localparam int ACCESS_SEL_BIT = 8;
  localparam int REL_OFF_W = 11;
  localparam int ABS_LO_W = 8;
  localparam int LIT_W = 12;

  // Fast-access window: low half from bank zero, high half from bank 15.
  localparam logic [OFF_W-1:0] ACC_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hf;
  localparam logic [DD_W-1:0] DATA_ZERO = 8'h00;

  // Four non-overlapping phases of one instruction cycle.
  typedef enum logic [3:0] {
    phase_one = 4'h1,
    phase_two = 4'h2,
    phase_three = 4'h4,
    phase_four = 4'h8
  } ifp_phase_t;

endpackage : ifp_pkg

// file: ifp_core_asserts.sv
`timescale 1ns/1ns

module ifp_core_chk #(
  parameter int NUM_BANKS = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [20:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  input wire logic [3:0] bank_select_value,
  input wire logic [11:0] dm_addr,
  input wire logic dm_rd,
  input wire logic dm_wr,
  input wire logic [7:0] dm_wdata,
  input wire logic [7:0] dm_rdata
);
  logic [1:0] ph;
  logic [15:0] ir;
  logic [7:0] rd_byte;
  logic [20:0] bra_disp;
  logic is_bra;
  logic is_tst;

  // Word offsets are doubled so that the byte address stays even.
  assign bra_disp = {{9{ir[10]}}, ir[10:0], 1'b0};
  assign is_bra = ir[15:11] == ifp_pkg::OP_BRANCH_REL;
  assign is_tst = dm_rd && ir[15:9] == ifp_pkg::OP_TEST_SKIP;

  // Reset parks the phase in four, so the first edge opens phase one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 2'h3;
      ir <= 16'h0000;
      rd_byte <= 8'h00;
    end else begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) ir <= pm_rdata;
      if (dm_rd) rd_byte <= dm_rdata;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  pc_even_a: assert property (pm_addr[0] == 1'b0)
    else $error("program address is odd");
  pc_phase_a: assert property ($changed(pm_addr) |-> ph == 2'h0)
    else $error("program address moved outside phase one");
  pc_hold_a: assert property (ph == 2'h0 |=> $stable(pm_addr) [*3])
    else $error("program address did not stand a full cycle");
  rd_phase_a: assert property (dm_rd |-> ph == 2'h1 && !dm_wr)
    else $error("data read outside phase two");
  wr_phase_a: assert property (dm_wr |-> ph == 2'h3)
    else $error("data write outside phase four");
  wr_data_a: assert property (dm_wr |-> dm_wdata == rd_byte)
    else $error("moved byte differs from source byte");
  acc_win_a: assert property (is_tst && !ir[8] |->
    dm_addr == {{4{ir[7]}}, ir[7:0]})
    else $error("fast window address wrong");
  bank_sel_a: assert property (is_tst && ir[8] |->
    dm_addr == {bank_select_value, ir[7:0]})
    else $error("banked address wrong");
  bra_target_a: assert property (ph == 2'h0 && is_bra |->
    ##4 pm_addr == $past(pm_addr, 4) + $past(bra_disp, 4))
    else $error("relative branch target wrong");
  bra_flush_a: assert property (ph == 2'h0 && is_bra |->
    ##4 !dm_rd [*4])
    else $error("flushed slot touched data memory");

  cover property (dm_wr);
  cover property (ph == 2'h0 && is_bra);
  cover property (is_tst && ir[8]);
endmodule : ifp_core_chk

bind ifp_core ifp_core_chk #(.NUM_BANKS(NUM_BANKS)) ifp_core_chk_i (
  .clk(clk), .rst_b(rst_b), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
  .bank_select_value(bank_select_value), .dm_addr(dm_addr),
  .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

// file: ifp_mem_model.sv
`timescale 1ns/1ns

module ifp_mem_model (
  input wire logic clk,
  input wire logic [20:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire logic [11:0] dm_addr,
  input wire logic dm_rd,
  input wire logic dm_wr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata
);
  logic [15:0] pm [0:63];
  logic [7:0] dm [0:4095];
  logic [7:0] last_rd = 8'h00;

  // Each word spans an even and odd byte pair, so bit zero is ignored.
  assign pm_rdata = pm[pm_addr[6:1]];
  // An idle read bus shows the inverse of the last byte, never a stale copy.
  assign dm_rdata = dm_rd ? dm[dm_addr] : ~last_rd;

  // All sixteen banks exist and start cleared.
  initial begin
    for (int i = 0; i < 4096; i++) dm[i] = 8'h00;
    for (int i = 0; i < 64; i++) pm[i] = 16'h0000;
  end

  // Writes land on the edge that closes the write strobe cycle.
  always @(posedge clk) begin
    if (dm_rd) last_rd <= dm[dm_addr];
    if (dm_wr) dm[dm_addr] <= dm_wdata;
  end
endmodule : ifp_mem_model

// file: tb_top.sv
`timescale 1ns/1ns
`define IFP_CHK(n, e, s) begin \
  checks_done++; \
  if ((s) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); \
  end \
end

module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] bank_select_value = 4'h3;
  logic [20:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [11:0] dm_addr;
  logic dm_rd;
  logic dm_wr;
  logic [7:0] dm_wdata;
  logic [7:0] dm_rdata;
  int mismatches = 0;
  int checks_done = 0;
  logic [19:0] wlog [$];
  // Move, call over a decoy move, pointer load, branch, skips on zero and a
  // closing self loop; a wrong call target would run the decoy and write.
  localparam logic [15:0] PROG [0:21] = '{16'hc123, 16'hf456, 16'hec06,
    16'hf000, 16'hc111, 16'hf222, 16'hee00, 16'hf012, 16'hd002, 16'hc111,
    16'hf333, 16'h6620, 16'hc123, 16'hf444, 16'h6780, 16'hc123, 16'hf555,
    16'h6690, 16'hc123, 16'hf666, 16'hef14, 16'hf000};

  initial forever #50 clk = ~clk;

  ifp_core ifp_core_i (.clk(clk), .rst_b(rst_b), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .bank_select_value(bank_select_value),
    .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
  ifp_mem_model ifp_mem_model_i (.clk(clk), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

  // Every write is logged, so a stray one from a skipped word shows up.
  always @(posedge clk) if (dm_wr === 1'b1) wlog.push_back({dm_addr, dm_wdata});

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // The byte at 380 and decoys at 320 and 090 make a wrong window or bank flip a skip.
  task automatic load_image;
    for (int i = 0; i < 22; i++) ifp_mem_model_i.pm[i] = PROG[i];
    ifp_mem_model_i.dm[12'h123] = 8'h5a;
    ifp_mem_model_i.dm[12'h380] = 8'h01;
    ifp_mem_model_i.dm[12'h320] = 8'h09;
    ifp_mem_model_i.dm[12'h090] = 8'h07;
  endtask : load_image

  task automatic check_reset;
    `IFP_CHK("pm_addr", 21'h000000, pm_addr)
    `IFP_CHK("dm_rd", 1'b0, dm_rd)
    `IFP_CHK("dm_wr", 1'b0, dm_wr)
  endtask : check_reset

  // Run until the self loop has turned twice; a hang ends the run.
  task automatic run_to_loop;
    int n;
    int hits;
    n = 0;
    hits = 0;
    while (n < 600 && hits < 12) begin
      @(negedge clk);
      n++;
      if (pm_addr === 21'h000028) hits++;
    end
    if (hits < 12) begin
      mismatches++;
      $display("[ERR] loop visits exp %0d got %0d", 12, hits);
      summarize();
    end
  endtask : run_to_loop

  task automatic check_writes;
    `IFP_CHK("write count", 2, wlog.size())
    `IFP_CHK("first move", 20'h4565a, wlog[0])
    `IFP_CHK("banked move", 20'h5555a, wlog[1])
    `IFP_CHK("dest byte", 8'h5a, ifp_mem_model_i.dm[12'h456])
  endtask : check_writes

  initial begin
    repeat (2) @(negedge clk);
    load_image();
    check_reset();
    repeat (18) @(negedge clk);
    rst_b = 1'b1;
    run_to_loop();
    check_writes();
    summarize();
  end
endmodule : tb_top
